// *** design/spi_seq_defines.svh ***
// Constants of the serial master frame sequencer
`ifndef SPI_SEQ_DEFINES_SVH
`define SPI_SEQ_DEFINES_SVH
`define FRAME_BITS     32
`define BIT_CNT_W      5
`define FIFO_DEPTH     8
`define FIFO_PTR_W     3
`define FIFO_LVL_W     4
`define DELAY_W        8
`define DIV_W          8
`define BURST_W        8
`define LAST_BIT       5'h1f
`define LVL_ZERO       4'h0
`define LVL_ONE        4'h1
`endif

// *** design/spi_seq_pkg.sv ***
// Types shared by the serial master frame sequencer
package spi_seq_pkg;
  // Communication direction
  typedef enum logic [1:0] {
    MODE_FULL = 2'h0,
    MODE_TX   = 2'h1,
    MODE_RX   = 2'h2
  } mode_e;
  // Frame sequencer states, Gray along idle-lead-shift-trail-gap
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_SHIFT = 3'h3,
    ST_TRAIL = 3'h2,
    ST_GAP   = 3'h6,
    ST_HOLD  = 3'h7
  } state_e;
endpackage

// *** design/fifo_if.sv ***
// Push/pop port between the sequencer and a word store
`timescale 1ns/100ps
`default_nettype none
`include "spi_seq_defines.svh"
interface fifo_if;
  logic                     push;      // Write one word
  logic [`FRAME_BITS-1:0]   pushData;  // Word to write
  logic                     pop;       // Drop oldest word
  logic [`FRAME_BITS-1:0]   popData;   // Oldest word
  logic [`FIFO_LVL_W-1:0]   level;     // Fill level
  logic                     full;      // No room left
  logic                     empty;     // Nothing held
  modport owner (output push, output pushData, output pop,
                 input popData, input level, input full, input empty);
  modport store (input push, input pushData, input pop,
                 output popData, output level, output full, output empty);
endinterface
`default_nettype wire

// *** design/word_fifo.sv ***
// Small synchronous word FIFO used for both data directions
`timescale 1ns/100ps
`default_nettype none
`include "spi_seq_defines.svh"
module word_fifo (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  fifo_if.store     port
);
  // All state of the store
  typedef struct packed {
    logic [`FIFO_DEPTH-1:0][`FRAME_BITS-1:0] mem;
    logic [`FIFO_PTR_W-1:0]                  wrPtr;
    logic [`FIFO_PTR_W-1:0]                  rdPtr;
    logic [`FIFO_LVL_W-1:0]                  count;
  } fifo_s;

  fifo_s s_q;  // Registered state
  fifo_s s_d;  // Next state
  logic  doPush;
  logic  doPop;

  ////////////////////////////////////////////////////////////////////////
  // Pushes into a full store and pops from an empty one are ignored
  always_comb begin
    s_d    = s_q;
    doPush = port.push && !port.full;
    doPop  = port.pop && !port.empty;
    if (doPush) begin
      s_d.mem[s_q.wrPtr] = port.pushData;
      s_d.wrPtr          = s_q.wrPtr + 3'h1;
    end
    if (doPop) begin
      s_d.rdPtr = s_q.rdPtr + 3'h1;
    end
    if (doPush && !doPop) begin
      s_d.count = s_q.count + 4'h1;
    end else if (doPop && !doPush) begin
      s_d.count = s_q.count - 4'h1;
    end
  end

  // State register, memory contents left alone by reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q.wrPtr <= '0;
      s_q.rdPtr <= '0;
      s_q.count <= '0;
      s_q.mem   <= s_d.mem;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.popData = s_q.mem[s_q.rdPtr];
  assign port.level   = s_q.count;
  assign port.full    = (s_q.count == 4'h8);
  assign port.empty   = (s_q.count == `LVL_ZERO);
endmodule
`default_nettype wire

// *** design/spi_master_transfer_sequencer.sv ***
// Serial master frame sequencer: chip select, clock, delays, FIFO events
`timescale 1ns/100ps
`default_nettype none
`include "spi_seq_defines.svh"
module spi_master_transfer_sequencer (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       enableSet,
  input  wire logic                       enableClr,
  output logic                            enableOut,
  output logic                            busy,
  input  wire spi_seq_pkg::mode_e         mode,
  input  wire logic                       burstMode,
  input  wire logic [`BURST_W-1:0]        burstLen,
  input  wire logic                       dmaSelect,
  input  wire logic [`DIV_W-1:0]          clockDivider,
  input  wire logic [`DELAY_W-1:0]        select_to_clock_delay,
  input  wire logic [`DELAY_W-1:0]        clock_to_deselect_delay,
  input  wire logic [`DELAY_W-1:0]        min_idle_interval,
  input  wire logic                       txWrite,
  input  wire logic [`FRAME_BITS-1:0]     txData,
  input  wire logic                       rxRead,
  output logic      [`FRAME_BITS-1:0]     rxData,
  output logic      [`FIFO_LVL_W-1:0]     txLevel,
  output logic      [`FIFO_LVL_W-1:0]     rxLevel,
  output logic                            txFifoIrq,
  output logic                            txDmaReq,
  output logic                            rxFifoIrq,
  output logic                            rxDmaReq,
  output logic                            txDoneIrq,
  output logic                            rxDoneIrq,
  output logic                            chip_select_out_n,
  output logic                            serial_clock_out,
  output logic                            serialDataOut,
  input  wire logic                       serialDataIn
);
  import spi_seq_pkg::*;

  // All sequencer state
  typedef struct packed {
    state_e                  state;
    logic                    enable;
    logic                    sck;
    logic                    csN;
    logic                    mosi;
    logic [`FRAME_BITS-1:0]  shift;
    logic [`BIT_CNT_W-1:0]   bitCnt;
    logic [`DELAY_W:0]       delayCnt;
    logic [`DIV_W-1:0]       divCnt;
    logic [`BURST_W-1:0]     frameCnt;
    logic                    rxPend;
    logic [`FRAME_BITS-1:0]  rxHold;
    logic                    misoMeta;
    logic                    misoSync;
    logic [`FIFO_LVL_W-1:0]  txLvlPrev;
    logic [`FIFO_LVL_W-1:0]  rxLvlPrev;
    logic                    txIrq;
    logic                    txDma;
    logic                    rxIrq;
    logic                    rxDma;
    logic                    txDone;
    logic                    rxDone;
  } seq_s;

  seq_s                   s_q;        // Registered state
  seq_s                   s_d;        // Next state
  logic                   tick;       // Half serial clock period enable
  logic                   rxRoom;     // Receive buffer can take a frame
  logic                   canStart;   // Frame may begin
  logic                   lastRise;   // Final rising edge this cycle
  logic [`FRAME_BITS-1:0] lastWord;   // Word completed on that edge
  logic [`BURST_W-1:0]    nextFrames; // Frames done incl. current

  fifo_if txPort ();  // Transmit side store
  fifo_if rxPort ();  // Receive side store

  word_fifo txFifo (.clk_sys(clk_sys), .rst_n(rst_n), .port(txPort));
  word_fifo rxFifo (.clk_sys(clk_sys), .rst_n(rst_n), .port(rxPort));

  ////////////////////////////////////////////////////////////////////////
  // Start condition; a word held in rxHold blocks frames
  always_comb begin
    // Only a full store with a word already parked withholds a frame
    rxRoom   = !(rxPort.full && s_q.rxPend);
    canStart = 1'b0;
    if (mode == MODE_RX) begin
      canStart = rxRoom;
    end else if (mode == MODE_TX) begin
      canStart = !txPort.empty;
    end else begin
      canStart = !txPort.empty && rxRoom;
    end
  end

  assign tick       = (s_q.divCnt == clockDivider);
  assign lastRise   = (s_q.state == ST_SHIFT) && tick && !s_q.sck
                      && (s_q.bitCnt == `LAST_BIT);
  assign lastWord   = {s_q.shift[`FRAME_BITS-2:0], s_q.misoSync};
  assign nextFrames = s_q.frameCnt + 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // FIFO ports: software pushes, sequencer pops and fills receive
  always_comb begin
    txPort.push     = txWrite;
    txPort.pushData = txData;
    txPort.pop      = 1'b0;
    rxPort.pop      = rxRead;
    rxPort.push     = 1'b0;
    rxPort.pushData = s_q.rxHold;
    // Transmit only never touches the receive store
    if (lastRise && mode != MODE_TX && !rxPort.full) begin
      rxPort.push     = 1'b1;
      rxPort.pushData = lastWord;
    end else if (s_q.rxPend && !rxPort.full) begin
      rxPort.push = 1'b1;
    end
    if (mode != MODE_RX && canStart && s_q.enable
        && (s_q.state == ST_IDLE || s_q.state == ST_HOLD)) begin
      txPort.pop = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    s_d          = s_q;
    s_d.txIrq    = 1'b0;
    s_d.txDma    = 1'b0;
    s_d.rxIrq    = 1'b0;
    s_d.rxDma    = 1'b0;
    s_d.txDone   = 1'b0;
    s_d.rxDone   = 1'b0;
    s_d.misoMeta = serialDataIn;
    s_d.misoSync = s_q.misoMeta;
    s_d.divCnt   = tick ? '0 : s_q.divCnt + 8'h01;
    s_d.enable   = (s_q.enable && !enableClr) || enableSet;
    s_d.txLvlPrev = txPort.level;
    s_d.rxLvlPrev = rxPort.level;
    // Level edge events, DMA request instead of interrupt when selected
    if (s_q.txLvlPrev == `LVL_ONE && txPort.level == `LVL_ZERO) begin
      s_d.txIrq = !dmaSelect;
      s_d.txDma = dmaSelect;
    end
    if (s_q.rxLvlPrev == `LVL_ZERO && rxPort.level == `LVL_ONE) begin
      s_d.rxIrq = !dmaSelect;
      s_d.rxDma = dmaSelect;
    end
    // Word parked in rxHold moves in once room appears
    if (s_q.rxPend && !rxPort.full) begin
      s_d.rxPend = 1'b0;
    end
    case (s_q.state)
      ST_IDLE: begin
        // Enable checked here, in trail and in hold, so clearing it ends after a frame
        if (s_q.enable && canStart) begin
          s_d.csN      = 1'b0;
          s_d.shift    = (mode == MODE_RX) ? '0 : txPort.popData;
          s_d.mosi     = (mode == MODE_RX) ? 1'b0 : txPort.popData[`FRAME_BITS-1];
          s_d.bitCnt   = '0;
          s_d.frameCnt = '0;
          s_d.delayCnt = {select_to_clock_delay, 1'b0};
          s_d.state    = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          if (s_q.delayCnt == '0) begin
            s_d.state = ST_SHIFT;
          end else begin
            s_d.delayCnt = s_q.delayCnt - 9'h001;
          end
        end
      end
      ST_SHIFT: begin
        if (tick && !s_q.sck) begin
          // Rising edge: sample receive line
          s_d.sck   = 1'b1;
          s_d.shift = lastWord;
          s_d.bitCnt = s_q.bitCnt + 5'h01;
          if (s_q.bitCnt == `LAST_BIT) begin
            if (mode != MODE_TX && rxPort.full) begin
              s_d.rxPend = 1'b1;
              s_d.rxHold = lastWord;
            end
            s_d.delayCnt = {clock_to_deselect_delay, 1'b0};
            s_d.state    = ST_TRAIL;
          end
        end else if (tick) begin
          // Falling edge: present next bit
          s_d.sck  = 1'b0;
          s_d.mosi = s_q.shift[`FRAME_BITS-1];
        end
      end
      ST_TRAIL: begin
        if (tick) begin
          s_d.sck = 1'b0;
          if (s_q.delayCnt == '0) begin
            if (burstMode && nextFrames < burstLen && s_q.enable) begin
              s_d.frameCnt = nextFrames;
              s_d.state    = ST_HOLD;
            end else begin
              s_d.csN      = 1'b1;
              s_d.txDone   = (mode != MODE_RX);
              s_d.rxDone   = (mode != MODE_TX);
              s_d.frameCnt = '0;
              s_d.delayCnt = {min_idle_interval, 1'b0};
              s_d.state    = ST_GAP;
              if (burstMode) begin
                s_d.enable = enableSet;
              end
            end
          end else begin
            s_d.delayCnt = s_q.delayCnt - 9'h001;
          end
        end
      end
      ST_HOLD: begin
        // Select stays low until the next word or receive room arrives, or enable is cleared
        if (!s_q.enable) begin
          s_d.csN      = 1'b1;
          s_d.txDone   = (mode != MODE_RX);
          s_d.rxDone   = (mode != MODE_TX);
          s_d.delayCnt = {min_idle_interval, 1'b0};
          s_d.state    = ST_GAP;
        end else if (canStart) begin
          s_d.shift  = (mode == MODE_RX) ? '0 : txPort.popData;
          s_d.mosi   = (mode == MODE_RX) ? 1'b0 : txPort.popData[`FRAME_BITS-1];
          s_d.bitCnt = '0;
          s_d.state  = ST_SHIFT;
        end
      end
      ST_GAP: begin
        if (tick) begin
          if (s_q.delayCnt == '0) begin
            s_d.state = ST_IDLE;
          end else begin
            s_d.delayCnt = s_q.delayCnt - 9'h001;
          end
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.csN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign enableOut         = s_q.enable;
  assign busy              = (s_q.state != ST_IDLE);
  assign rxData            = rxPort.popData;
  assign txLevel           = txPort.level;
  assign rxLevel           = rxPort.level;
  assign txFifoIrq         = s_q.txIrq;
  assign txDmaReq          = s_q.txDma;
  assign rxFifoIrq         = s_q.rxIrq;
  assign rxDmaReq          = s_q.rxDma;
  assign txDoneIrq         = s_q.txDone;
  assign rxDoneIrq         = s_q.rxDone;
  assign chip_select_out_n = s_q.csN;
  assign serial_clock_out  = s_q.sck;
  assign serialDataOut     = s_q.mosi;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_no_start_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.state == ST_IDLE && !s_q.enable) |=> (s_q.state == ST_IDLE))
    else $error("frame started while disabled");
  a_tx_push_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (txWrite && !txPort.full && !txPort.pop) |=> (txPort.level == $past(txPort.level) + 4'h1))
    else $error("write did not raise transmit level");
  a_level_one_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (txPort.empty && txWrite && !txPort.pop) |=> (txLevel == `LVL_ONE))
    else $error("one held word did not read level one");
  a_lead_no_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.state == ST_LEAD) |-> (!serial_clock_out && !chip_select_out_n))
    else $error("clock ran during lead delay");
  a_tx_level_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(txLevel) == `LVL_ONE && txLevel == `LVL_ZERO) |=> (txFifoIrq || txDmaReq))
    else $error("missing transmit level event");
  a_rx_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lastRise && mode != MODE_TX && !rxRead)
    |=> (rxPort.level == $past(rxPort.level) + 4'h1 || s_q.rxPend))
    else $error("final word not captured");
  a_duplex_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(chip_select_out_n) && mode == MODE_FULL) |-> (txDoneIrq && rxDoneIrq))
    else $error("completion events missing");
  a_rx_level_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rxLevel) == `LVL_ZERO && rxLevel == `LVL_ONE) |=> (rxFifoIrq || rxDmaReq))
    else $error("missing receive level event");
  a_gap_deselect: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.state == ST_GAP) |-> chip_select_out_n)
    else $error("select asserted during idle gap");
  a_rx_only_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(chip_select_out_n) && mode == MODE_RX) |-> (rxDoneIrq && !txDoneIrq))
    else $error("wrong completion in receive only");
  a_full_withhold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_q.state == ST_IDLE && s_q.rxPend && rxPort.full && mode != MODE_TX)
    |=> (s_q.state == ST_IDLE))
    else $error("frame started with full receive buffer");
  a_tx_only_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mode == MODE_TX && !rxRead) |=> ($stable(rxLevel) && !rxDoneIrq))
    else $error("receive side moved in transmit only");
endmodule
`default_nettype wire

// *** verif/serial_slave_model.sv ***
// Behavioural serial slave that answers the sequencer's frames
`timescale 1ns/100ps
`default_nettype none
module serial_slave_model (
  input  wire logic chipSelN,  // Active low select
  input  wire logic sck,       // Serial clock, idle low
  input  wire logic mosi,      // Data from master
  output logic      miso       // Data to master
);
  logic [31:0] sh;       // Word being shifted out
  logic [31:0] inWord;   // Incoming shift
  logic [31:0] sent[$];  // Words whose first bit went out
  logic [31:0] got[$];   // Whole words taken in
  int          nBits;    // Rising edges since select
  int          nSent;    // Words loaded so far
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miso = 1'b0;
    nBits = 0;
    nSent = 0;
  end
  // Select: load a word that differs per frame, MSB first on the line
  always @(negedge chipSelN) begin
    sh = 32'h5a0f3c00 | 32'(nSent);
    nSent++;
    nBits = 0;
    miso = sh[31];
  end
  // Sample on rising clock; a burst keeps select, so words split by count
  always @(posedge sck) begin
    if (!chipSelN) begin
      if (nBits % 32 == 0) sent.push_back(sh);
      inWord = {inWord[30:0], mosi};
      nBits++;
      if (nBits % 32 == 0) got.push_back(inWord);
    end
  end
  // Change on falling clock; a spare load at frame end is never recorded
  always @(negedge sck) begin
    if (!chipSelN) begin
      if (nBits % 32 == 0) begin
        sh = 32'h5a0f3c00 | 32'(nSent);
        nSent++;
      end
      miso = sh[31 - (nBits % 32)];
    end
  end
  // Released line shows the inverse, so a stale bit cannot pass
  always @(posedge chipSelN) begin
    miso = ~miso;
  end
endmodule
`default_nettype wire

// *** verif/spi_master_transfer_sequencer_bench.sv ***
// Self-checking bench of the serial master frame sequencer
`timescale 1ns/100ps
`default_nettype none
module spi_master_transfer_sequencer_bench;
  import spi_seq_pkg::*;
  logic clk_sys = 1'b0;  // 20 MHz system clock
  logic rst_n, enableSet, enableClr, txWrite, rxRead, burstMode, dmaSelect;
  logic enableOut, busy, txFifoIrq, txDmaReq, rxFifoIrq, rxDmaReq, txDoneIrq, rxDoneIrq;
  logic chip_select_out_n, serial_clock_out, serialDataOut, serialDataIn;
  logic [7:0] burstLen, clockDivider;  // Fixed settings
  logic [7:0] select_to_clock_delay, clock_to_deselect_delay, min_idle_interval;
  logic [31:0] txData, rxData;         // Data port words
  logic [3:0] txLevel, rxLevel;        // Fill levels
  mode_e mode;                         // Direction
  wire logic [5:0] evs;                // Event outputs
  int ev [6];                          // Event pulse counts
  int nFrames, nEnds, nRise, nFail, nChecks;
  int gapRun, lastGap, leadRun, lastLead;
  logic csPrev, sckPrev, sckOn;
  assign evs = {rxDoneIrq, txDoneIrq, rxDmaReq, rxFifoIrq, txDmaReq, txFifoIrq};
  ////////////////////////////////////////////////////////////////////////////////
  spi_master_transfer_sequencer dut_u (.clk_sys, .rst_n, .enableSet, .enableClr, .enableOut,
    .busy, .mode, .burstMode, .burstLen, .dmaSelect, .clockDivider, .select_to_clock_delay,
    .clock_to_deselect_delay, .min_idle_interval, .txWrite, .txData, .rxRead, .rxData,
    .txLevel, .rxLevel, .txFifoIrq, .txDmaReq, .rxFifoIrq, .rxDmaReq, .txDoneIrq, .rxDoneIrq,
    .chip_select_out_n, .serial_clock_out, .serialDataOut, .serialDataIn);
  serial_slave_model slave_u (.chipSelN(chip_select_out_n), .sck(serial_clock_out),
    .mosi(serialDataOut), .miso(serialDataIn));
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: pulses, select edges, clock rises, lead and gap lengths
  always @(posedge clk_sys) begin
    for (int i = 0; i < 6; i++) begin
      if (evs[i] === 1'b1) ev[i]++;
    end
    if (csPrev === 1'b1 && chip_select_out_n === 1'b0) nFrames++;
    if (csPrev === 1'b0 && chip_select_out_n === 1'b1) nEnds++;
    if (sckPrev === 1'b0 && serial_clock_out === 1'b1) nRise++;
    if (chip_select_out_n === 1'b1) begin
      gapRun++;
      leadRun = 0;
      sckOn = 1'b0;
    end else begin
      if (gapRun > 0) lastGap = gapRun;
      gapRun = 0;
      if (serial_clock_out === 1'b1 && !sckOn) lastLead = leadRun;
      if (serial_clock_out === 1'b1) sckOn = 1'b1;
      if (!sckOn) leadRun++;
    end
    csPrev = chip_select_out_n;
    sckPrev = serial_clock_out;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    nChecks++;
    if (got < lo || got > hi) begin
      nFail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Strobes: bit 0 enable set, bit 1 enable clear, bit 2 receive read
  task automatic pulse_ctl(input logic [2:0] sel);
    @(negedge clk_sys);
    {rxRead, enableClr, enableSet} = sel;
    @(negedge clk_sys);
    {rxRead, enableClr, enableSet} = 3'h0;
  endtask
  task automatic pulse_tx(input logic [31:0] w);
    @(negedge clk_sys);
    txWrite = 1'b1;
    txData = w;
    @(negedge clk_sys);
    txWrite = 1'b0;
  endtask
  // Bounded wait on a monitor count, then let late pulses land
  task automatic wait_for(ref int cnt, input int n);
    int t;
    t = 0;
    while (cnt < n && t < 8000) begin
      @(negedge clk_sys);
      t++;
    end
    check_range("wait bound", 0, 7999, t);
    repeat (40) @(negedge clk_sys);
  endtask
  // Read words out, each against what the slave sent
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      check_val("rx word", slave_u.sent.pop_front(), rxData);
      pulse_ctl(3'h4);
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task automatic do_reset(input mode_e m, input logic dma, input logic bst);
    @(negedge clk_sys);
    rst_n = 1'b0;
    mode = m;
    dmaSelect = dma;
    burstMode = bst;
    repeat (4) @(negedge clk_sys);
    slave_u.sent.delete();
    slave_u.got.delete();
    ev = '{default: 0};
    {nFrames, nEnds, nRise} = {32'd0, 32'd0, 32'd0};
    rst_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Full duplex, two queued words, events on irq outputs
  task automatic test_full();
    do_reset(MODE_FULL, 1'b0, 1'b0);
    pulse_tx(32'ha1b2c3d4);
    repeat (2) @(negedge clk_sys);
    check_val("txLevel", 32'h1, 32'(txLevel));
    repeat (60) @(negedge clk_sys);
    check_val("frames while disabled", 32'h0, 32'(nFrames));
    pulse_tx(32'h0f1e2d3c);
    pulse_ctl(3'h1);
    wait_for(nEnds, 2);
    check_val("tx fifo irq", 32'h1, 32'(ev[0]));
    check_val("rx fifo irq", 32'h1, 32'(ev[2]));
    check_val("tx done", 32'h2, 32'(ev[4]));
    check_val("rx done", 32'h2, 32'(ev[5]));
    check_val("clock rises", 32'd64, 32'(nRise));
    check_val("rxLevel", 32'h2, 32'(rxLevel));
    check_range("lead cycles", 12, 20, lastLead);
    check_range("gap cycles", 20, 32, lastGap);
    check_val("slave word a", 32'ha1b2c3d4, slave_u.got.pop_front());
    check_val("slave word b", 32'h0f1e2d3c, slave_u.got.pop_front());
    drain(2);
  endtask
  // Transmit only with DMA requests; receive side stays silent
  task automatic test_tx();
    do_reset(MODE_TX, 1'b1, 1'b0);
    pulse_ctl(3'h1);
    pulse_tx(32'h3c5a96e1);
    wait_for(nEnds, 1);
    check_val("tx dma", 32'h1, 32'(ev[1]));
    check_val("tx irq", 32'h0, 32'(ev[0]));
    check_val("rx events", 32'h0, 32'(ev[2] + ev[3] + ev[5]));
    check_val("rxLevel", 32'h0, 32'(rxLevel));
    check_val("slave word", 32'h3c5a96e1, slave_u.got.pop_front());
  endtask
  // Receive only: fill to the parked word, resume on read, clear enable mid-frame
  task automatic test_rx();
    do_reset(MODE_RX, 1'b1, 1'b0);
    pulse_ctl(3'h1);
    repeat (3) @(negedge clk_sys);
    check_val("select at once", 32'h0, 32'(chip_select_out_n));
    wait_for(nEnds, 9);
    repeat (600) @(negedge clk_sys);
    check_val("frames while full", 32'd9, 32'(nFrames));
    check_val("rxLevel full", 32'h8, 32'(rxLevel));
    check_val("rx dma", 32'h1, 32'(ev[3]));
    check_val("rx done", 32'd9, 32'(ev[5]));
    check_val("tx done", 32'h0, 32'(ev[4]));
    drain(1);
    wait_for(nFrames, 10);
    pulse_ctl(3'h2);
    wait_for(nEnds, 10);
    repeat (600) @(negedge clk_sys);
    check_val("frames after clear", 32'd10, 32'(nFrames));
    check_val("rises after clear", 32'd320, 32'(nRise));
    check_val("enable cleared", 32'h0, 32'(enableOut));
    drain(9);
    check_val("rxLevel empty", 32'h0, 32'(rxLevel));
  endtask
  // Burst of two with the transmit store running dry in between
  task automatic test_burst();
    do_reset(MODE_FULL, 1'b0, 1'b1);
    pulse_tx(32'h76543210);
    pulse_ctl(3'h1);
    wait_for(nRise, 32);
    repeat (200) @(negedge clk_sys);
    check_val("select held", 32'h0, 32'(chip_select_out_n));
    pulse_tx(32'h89abcdef);
    wait_for(nEnds, 1);
    check_val("one select", 32'h1, 32'(nFrames));
    check_val("clock rises", 32'd64, 32'(nRise));
    check_val("burst end enable", 32'h0, 32'(enableOut));
    check_val("busy cleared", 32'h0, 32'(busy));
    check_val("done pulses", 32'h2, 32'(ev[4] + ev[5]));
    drain(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stopTest();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog well past the four scenarios
  initial begin
    repeat (40000) @(posedge clk_sys);
    nFail++;
    stopTest();
  end
  // Main sequence; delays give 12 and 20 cycle lead and gap at divider 3
  initial begin
    {rst_n, enableSet, enableClr, txWrite, rxRead, burstMode, dmaSelect} = 7'h0;
    {nFail, nChecks, gapRun, leadRun} = {32'd0, 32'd0, 32'd0, 32'd0};
    mode = MODE_FULL;
    txData = 32'h0;
    burstLen = 8'h02;
    clockDivider = 8'h03;
    select_to_clock_delay = 8'h01;
    clock_to_deselect_delay = 8'h01;
    min_idle_interval = 8'h02;
    test_full();
    test_tx();
    test_rx();
    test_burst();
    stopTest();
  end
endmodule
`default_nettype wire
